// ===== verilog/pfc_pkg.sv
// Constants, command codes and types of the parallel flash host controller.
package pfc_pkg;
	localparam int       CLK_NS          = 40;
	localparam int       WR_PULSE_NS     = 40;
	localparam int       RD_ACCESS_NS    = 150;
	localparam int       VPP_SETUP_NS    = 100;
	localparam int       PROG_PULSE_US   = 10;
	localparam int       ERASE_PULSE_US  = 9500;
	localparam int       RECOVERY_US     = 6;
	localparam int       SYNC_STAGES     = 2;
	localparam int       WR_PULSE_CYC    = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int       RD_STROBE_CYC   = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam int       VPP_SETUP_CYC   = (VPP_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int       PROG_PULSE_CYC  = (PROG_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int       ERASE_PULSE_CYC = (ERASE_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int       RECOVERY_CYC    = (RECOVERY_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int       PROG_TRIES      = 25;
	localparam int       ERASE_TRIES     = 1000;
	localparam int       TIMER_W         = 18;
	localparam int       TRIES_W         = 10;
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_SIG       = 8'h90;
	localparam logic [7:0] CMD_ERASE     = 8'h20;
	localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
	localparam logic [7:0] CMD_PROG      = 8'h40;
	localparam logic [7:0] CMD_PROG_VFY  = 8'hC0;
	localparam logic [7:0] CMD_RESET     = 8'hFF;
	localparam logic [7:0] ERASED_BYTE   = 8'hFF;
	localparam logic [7:0] PRECOND_BYTE  = 8'h00;
	localparam logic [15:0] ADDR_RESET   = 16'h0000;
	localparam logic [7:0] DATA_RESET    = 8'h00;

	typedef enum logic [2:0] {
		OP_READ  = 3'b000,
		OP_SIG   = 3'b001,
		OP_ID_A9 = 3'b010,
		OP_PROG  = 3'b011,
		OP_ERASE = 3'b100,
		OP_RESET = 3'b101
	} pfc_op_type;
endpackage : pfc_pkg

// ===== verilog/pfc_cyc_if.sv
// Request and answer group between the flow controller and the bus cycle engine.
interface pfc_cyc_if;
	logic        req;
	logic        wr;
	logic        a9;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        done;
	logic [7:0]  rdata;

	modport ctrl (output req, output wr, output a9, output addr, output wdata,
		input done, input rdata);
	modport eng  (input req, input wr, input a9, input addr, input wdata,
		output done, output rdata);
endinterface : pfc_cyc_if

// ===== verilog/pfc_cycle.sv
// Bus cycle engine: one write or read cycle on the flash pins per request.
module pfc_cycle
	import pfc_pkg::*;
(
	input  wire logic  i_clk_sys,
	input  wire logic  i_rst_n,
	pfc_cyc_if.eng     cyc,
	output logic       o_ce_n,
	output logic       o_oe_n,
	output logic       o_we_n,
	output logic [15:0] o_addr,
	output logic       o_a9_high,
	input  wire logic [7:0] i_data_pins,
	output logic [7:0] o_data_pins,
	output logic       o_data_oe
);
	typedef enum logic [1:0] {
		E_IDLE   = 2'b00,
		E_SETUP  = 2'b01,
		E_STROBE = 2'b10,
		E_HOLD   = 2'b11
	} pfc_eng_type;

	pfc_eng_type state;
	logic        is_wr;
	logic [3:0]  cnt;
	logic [7:0]  dq_meta;
	logic [7:0]  dq_sync;

	// pin data is asynchronous to our clock
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dq_meta <= DATA_RESET;
			dq_sync <= DATA_RESET;
		end else begin
			dq_meta <= i_data_pins;
			dq_sync <= dq_meta;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state       <= E_IDLE;
			is_wr       <= 1'b0;
			cnt         <= 4'h0;
			o_ce_n      <= 1'b1;
			o_oe_n      <= 1'b1;
			o_we_n      <= 1'b1;
			o_addr      <= ADDR_RESET;
			o_a9_high   <= 1'b0;
			o_data_pins <= DATA_RESET;
			o_data_oe   <= 1'b0;
			cyc.rdata   <= DATA_RESET;
		end else begin
			case (state)
				E_IDLE: begin
					if (cyc.req) begin
						state       <= E_SETUP;
						is_wr       <= cyc.wr;
						o_addr      <= cyc.addr;
						o_a9_high   <= cyc.a9;
						o_ce_n      <= 1'b0;
						o_data_pins <= cyc.wdata;
						o_data_oe   <= cyc.wr;
					end
				end
				E_SETUP: begin
					state  <= E_STROBE;
					o_we_n <= !is_wr;
					o_oe_n <= is_wr;
					cnt    <= is_wr ? 4'(WR_PULSE_CYC - 1) : 4'(RD_STROBE_CYC - 1);
				end
				E_STROBE: begin
					if (cnt == 4'h0) begin
						state  <= E_HOLD;
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						if (!is_wr) begin
							cyc.rdata <= dq_sync;
						end
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				E_HOLD: begin
					// address and data stay one cycle past the strobe for hold time
					state     <= E_IDLE;
					o_ce_n    <= 1'b1;
					o_data_oe <= 1'b0;
					o_a9_high <= 1'b0;
				end
				default: state <= E_IDLE;
			endcase
		end
	end

	assign cyc.done = (state == E_HOLD);
endmodule : pfc_cycle

// ===== verilog/pfc_host.sv
// Host controller: runs read, identity, program and erase flows on a parallel flash.
module pfc_host
	import pfc_pkg::*;
#(
	parameter int          ERASE_PULSE_CYCLES = ERASE_PULSE_CYC,
	parameter logic [15:0] LAST_ADDR          = 16'hFFFF,
	parameter int          ERASE_MAX_PULSES   = ERASE_TRIES
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_cmd_valid,
	input  wire logic [2:0] i_cmd_op,
	input  wire logic [15:0] i_cmd_addr,
	input  wire logic [7:0] i_cmd_data,
	output logic            o_cmd_ready,
	output logic            o_done,
	output logic [7:0]      o_rdata,
	output logic            o_fail,
	output logic            o_ce_n,
	output logic            o_oe_n,
	output logic            o_we_n,
	output logic [15:0]     o_addr,
	output logic            o_a9_high,
	output logic            o_programming_supply_high,
	input  wire logic [7:0] i_data_pins,
	output logic [7:0]      o_data_pins,
	output logic            o_data_oe
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0000,
		S_VPP   = 4'b0001,
		S_WR1   = 4'b0010,
		S_WR2   = 4'b0011,
		S_PULSE = 4'b0100,
		S_VWR   = 4'b0101,
		S_RECOV = 4'b0110,
		S_RD    = 4'b0111,
		S_CHECK = 4'b1000,
		S_DONE  = 4'b1001
	} pfc_state_type;

	pfc_cyc_if cyc ();

	pfc_state_type        state;
	pfc_op_type           op;
	logic [15:0]          cmd_addr;
	logic [7:0]           cmd_data;
	logic [15:0]          cur_addr;
	logic                 precond;
	logic [TRIES_W-1:0]   tries;
	logic [TIMER_W-1:0]   timer;
	logic                 pflow;
	logic [7:0]           first_cmd;
	logic [7:0]           second_cmd;
	logic [7:0]           expect_byte;
	logic [15:0]          rd_addr;
	logic                 last_addr;

	assign pflow     = (op == OP_PROG) || precond;
	assign last_addr = (cur_addr == LAST_ADDR);

	always_comb begin
		case (op)
			OP_READ:  first_cmd = CMD_READ;
			OP_SIG:   first_cmd = CMD_SIG;
			OP_RESET: first_cmd = CMD_RESET;
			OP_PROG:  first_cmd = CMD_PROG;
			OP_ERASE: first_cmd = precond ? CMD_PROG : CMD_ERASE;
			default:  first_cmd = CMD_READ;
		endcase
	end

	always_comb begin
		case (op)
			OP_RESET: second_cmd = CMD_RESET;
			OP_PROG:  second_cmd = cmd_data;
			OP_ERASE: second_cmd = precond ? PRECOND_BYTE : CMD_ERASE;
			default:  second_cmd = CMD_RESET;
		endcase
	end

	always_comb begin
		expect_byte = pflow ? (precond ? PRECOND_BYTE : cmd_data) : ERASED_BYTE;
		case (op)
			OP_READ:            rd_addr = cmd_addr;
			OP_SIG, OP_ID_A9:   rd_addr = {15'h0000, cmd_addr[0]};
			default:            rd_addr = cur_addr;
		endcase
	end

	// cycle requests are levels; the engine only looks at them while idle
	always_comb begin
		cyc.req   = 1'b0;
		cyc.wr    = 1'b0;
		cyc.a9    = 1'b0;
		cyc.addr  = cur_addr;
		cyc.wdata = first_cmd;
		case (state)
			S_WR1: begin
				cyc.req = 1'b1;
				cyc.wr  = 1'b1;
			end
			S_WR2: begin
				cyc.req   = 1'b1;
				cyc.wr    = 1'b1;
				cyc.wdata = second_cmd;
			end
			S_VWR: begin
				cyc.req   = 1'b1;
				cyc.wr    = 1'b1;
				cyc.wdata = pflow ? CMD_PROG_VFY : CMD_ERASE_VFY;
			end
			S_RD: begin
				cyc.req  = 1'b1;
				cyc.addr = rd_addr;
				cyc.a9   = (op == OP_ID_A9);
			end
			default: cyc.req = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state    <= S_IDLE;
			op       <= OP_READ;
			cmd_addr <= ADDR_RESET;
			cmd_data <= DATA_RESET;
			cur_addr <= ADDR_RESET;
			precond  <= 1'b0;
			tries    <= '0;
			timer    <= '0;
		end else begin
			case (state)
				S_IDLE: begin
					if (i_cmd_valid) begin
						state    <= S_VPP;
						op       <= pfc_op_type'(i_cmd_op);
						cmd_addr <= i_cmd_addr;
						cmd_data <= i_cmd_data;
						cur_addr <= (i_cmd_op == OP_ERASE) ? ADDR_RESET : i_cmd_addr;
						precond  <= (i_cmd_op == OP_ERASE);
						tries    <= '0;
						timer    <= TIMER_W'(VPP_SETUP_CYC);
					end
				end
				S_VPP: begin
					if (timer == '0) begin
						state <= (op == OP_ID_A9) ? S_RD : S_WR1;
					end else begin
						timer <= timer - 1'b1;
					end
				end
				S_WR1: begin
					if (cyc.done) begin
						if (op == OP_READ || op == OP_SIG) begin
							state <= S_RECOV;
							timer <= TIMER_W'(RECOVERY_CYC);
						end else begin
							state <= S_WR2;
						end
					end
				end
				S_WR2: begin
					if (cyc.done) begin
						if (op == OP_RESET) begin
							state <= S_DONE;
						end else begin
							state <= S_PULSE;
							// give the device stop timer its full pulse before the verify write
							timer <= pflow ? TIMER_W'(PROG_PULSE_CYC)
								: TIMER_W'(ERASE_PULSE_CYCLES);
						end
					end
				end
				S_PULSE: begin
					if (timer == '0) begin
						state <= S_VWR;
					end else begin
						timer <= timer - 1'b1;
					end
				end
				S_VWR: begin
					if (cyc.done) begin
						state <= S_RECOV;
						timer <= TIMER_W'(RECOVERY_CYC);
					end
				end
				S_RECOV: begin
					if (timer == '0) begin
						state <= S_RD;
					end else begin
						timer <= timer - 1'b1;
					end
				end
				S_RD: begin
					if (cyc.done) begin
						state <= (op == OP_PROG || op == OP_ERASE) ? S_CHECK : S_DONE;
					end
				end
				S_CHECK: begin
					if (cyc.rdata == expect_byte) begin
						tries <= '0;
						if (op == OP_PROG) begin
							state <= S_DONE;
						end else if (precond && last_addr) begin
							precond  <= 1'b0;
							cur_addr <= ADDR_RESET;
							state    <= S_WR1;
						end else if (precond) begin
							cur_addr <= cur_addr + 16'h0001;
							state    <= S_WR1;
						end else if (last_addr) begin
							state <= S_DONE;
						end else begin
							cur_addr <= cur_addr + 16'h0001;
							state    <= S_VWR;
						end
					end else if (pflow && tries == TRIES_W'(PROG_TRIES - 1)) begin
						state <= S_DONE;
					end else if (!pflow && tries == TRIES_W'(ERASE_MAX_PULSES - 1)) begin
						state <= S_DONE;
					end else begin
						tries <= tries + 1'b1;
						state <= S_WR1;
					end
				end
				S_DONE: state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	// result registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= DATA_RESET;
			o_fail  <= 1'b0;
		end else if (state == S_IDLE && i_cmd_valid) begin
			o_fail <= 1'b0;
		end else if (state == S_RD && cyc.done) begin
			o_rdata <= cyc.rdata;
		end else if (state == S_CHECK && cyc.rdata != expect_byte) begin
			o_fail <= (pflow && tries == TRIES_W'(PROG_TRIES - 1))
				|| (!pflow && tries == TRIES_W'(ERASE_MAX_PULSES - 1));
		end
	end

	// supply stays high across every flow except OP_ID_A9, which keeps it low; dropped when the flow ends
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_programming_supply_high <= 1'b0;
		end else if (state == S_IDLE && i_cmd_valid) begin
			o_programming_supply_high <= (i_cmd_op != OP_ID_A9);
		end else if (state == S_DONE) begin
			o_programming_supply_high <= 1'b0;
		end
	end

	assign o_cmd_ready = (state == S_IDLE);
	assign o_done      = (state == S_DONE);

	pfc_cycle u_cycle (
		.i_clk_sys   (i_clk_sys),
		.i_rst_n     (i_rst_n),
		.cyc         (cyc.eng),
		.o_ce_n      (o_ce_n),
		.o_oe_n      (o_oe_n),
		.o_we_n      (o_we_n),
		.o_addr      (o_addr),
		.o_a9_high   (o_a9_high),
		.i_data_pins (i_data_pins),
		.o_data_pins (o_data_pins),
		.o_data_oe   (o_data_oe)
	);
endmodule : pfc_host

// ===== test/pfc_flash_model.sv
// Behavioural flash device seen from its pins; programming only clears bits.
module pfc_flash_model
	import pfc_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'hA5,
	parameter logic [7:0] PART_ID  = 8'h3C,
	parameter int         ERASE_NS = 9500000
) (
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_a9_high,
	input  wire logic        i_supply_high,
	input  wire logic [7:0]  i_data,
	input  wire logic        i_prog_fail,
	output logic      [7:0]  o_data,
	output logic             o_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic    [7:0]  mem [65536];
	logic    [15:0] lat_addr, prog_addr;
	logic    [7:0]  prog_data, pend, mode;
	logic           prog_on, erase_on;
	realtime        t_pulse;
	wire logic [7:0] id_val = i_addr[0] ? PART_ID : MAKER_ID;

	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		mode     = CMD_READ;
		pend     = CMD_READ;
		prog_on  = 1'b0;
		erase_on = 1'b0;
	end
	always @(negedge i_we_n) if (!i_ce_n) lat_addr = i_addr;
	// a pulse cut short before the stop timer ends leaves the cells untouched
	always @(posedge i_we_n) if (!i_ce_n && i_supply_high) begin
		if (prog_on && $realtime - t_pulse >= 10000 && !i_prog_fail)
			mem[prog_addr] = mem[prog_addr] & prog_data;
		if (erase_on && $realtime - t_pulse >= ERASE_NS)
			foreach (mem[i]) mem[i] = 8'hFF;
		prog_on  = 1'b0;
		erase_on = 1'b0;
		t_pulse  = $realtime;
		if (pend == CMD_PROG) begin
			prog_addr = lat_addr;
			prog_data = i_data;
			prog_on   = 1'b1;
			pend      = CMD_READ;
		end else if (pend == i_data && (i_data == CMD_ERASE || i_data == CMD_RESET)) begin
			erase_on = (i_data == CMD_ERASE);
			mode     = CMD_READ;
			pend     = CMD_READ;
		end else begin
			pend = i_data;
			mode = i_data;
		end
	end
	assign #150 o_data = (i_a9_high || mode == CMD_SIG) ? id_val
		: (mode == CMD_ERASE_VFY) ? mem[lat_addr]
		: (mode == CMD_PROG_VFY) ? mem[prog_addr] : mem[i_addr];
	assign o_data_oe = !i_ce_n && !i_oe_n && i_we_n;
endmodule : pfc_flash_model

// ===== test/pfc_host_sva.sv
// Pin-level protocol checks on the flash host controller.
module pfc_host_sva
	import pfc_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_cmd_valid,
	input wire logic [2:0]  i_cmd_op,
	input wire logic        o_cmd_ready,
	input wire logic        o_ce_n,
	input wire logic        o_oe_n,
	input wire logic        o_we_n,
	input wire logic [15:0] o_addr,
	input wire logic        o_a9_high,
	input wire logic        o_programming_supply_high,
	input wire logic [7:0]  o_data_pins,
	input wire logic        o_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// cycles since the write strobe last rose, saturating
	logic [8:0] since_wr;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			since_wr <= 9'h1FF;
		end else if (!o_we_n) begin
			since_wr <= 9'h000;
		end else if (since_wr != 9'h1FF) begin
			since_wr <= since_wr + 9'h001;
		end
	end

	property p_write_gated;
		!o_we_n |-> !o_ce_n && o_oe_n && o_data_oe && o_programming_supply_high;
	endproperty
	a_write_gated: assert property (p_write_gated)
		else $error("write strobe without select, drive or supply");
	property p_strobe_hold;
		$fell(o_we_n) |=> $rose(o_we_n) && o_data_oe && !o_ce_n && $stable(o_addr)
			&& $stable(o_data_pins);
	endproperty
	a_strobe_hold: assert property (p_strobe_hold)
		else $error("address or data moved around the write strobe");
	property p_read_quiet;
		!o_oe_n |-> o_we_n && !o_ce_n && !o_data_oe;
	endproperty
	a_read_quiet: assert property (p_read_quiet)
		else $error("host drives data during a read");
	property p_read_len;
		$fell(o_oe_n) |-> !o_oe_n [*6] ##1 o_oe_n;
	endproperty
	a_read_len: assert property (p_read_len)
		else $error("read strobe not six cycles long");
	property p_id_addr;
		o_a9_high && !o_oe_n |-> !o_programming_supply_high && o_addr[15:10] == 6'h00
			&& o_addr[8:1] == 8'h00;
	endproperty
	a_id_addr: assert property (p_id_addr)
		else $error("identity read with other address lines high");
	property p_recovery;
		$fell(o_oe_n) |-> since_wr >= 9'(RECOVERY_CYC);
	endproperty
	a_recovery: assert property (p_recovery)
		else $error("read started before write recovery ended");
	property p_prog_pulse;
		!o_we_n && o_data_pins == CMD_PROG_VFY |-> since_wr >= 9'(PROG_PULSE_CYC - 1);
	endproperty
	a_prog_pulse: assert property (p_prog_pulse)
		else $error("program pulse ended too early");
	property p_read_cmd;
		i_cmd_valid && o_cmd_ready && i_cmd_op == OP_READ |->
			##[1:12] (!o_we_n && o_data_pins == CMD_READ);
	endproperty
	a_read_cmd: assert property (p_read_cmd)
		else $error("read flow did not write the read command");
endmodule : pfc_host_sva

// ===== test/tb_parallel_flash_command_interface.sv
// Self-checking bench: host controller driving a behavioural flash device.
module tb_parallel_flash_command_interface
	import pfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MAKER_ID  = 8'hA5; // arbitrary value
	localparam logic [7:0] PART_ID   = 8'h3C; // arbitrary value
	localparam int         ERASE_CYC = 20;
	logic        i_clk_sys   = 1'b0;
	logic        i_rst_n     = 1'b0;
	logic        i_cmd_valid = 1'b0;
	logic [2:0]  i_cmd_op    = 3'h0;
	logic [15:0] i_cmd_addr  = 16'h0000;
	logic [7:0]  i_cmd_data  = 8'h00;
	logic        prog_fail   = 1'b0;
	logic        o_cmd_ready, o_done, o_fail, o_ce_n, o_oe_n, o_we_n, o_a9_high;
	logic        o_programming_supply_high, o_data_oe, dev_oe;
	logic [15:0] o_addr;
	logic [7:0]  o_rdata, o_data_pins, i_data_pins, dev_d, last_bus = 8'h00;
	int          wr_cnt [256];
	int          mismatches = 0;
	int          num_checks = 0;

	always #20 i_clk_sys = ~i_clk_sys;
	// a released bus keeps toggling so a stale byte never reads as valid
	assign i_data_pins = o_data_oe ? o_data_pins : dev_oe ? dev_d : ~last_bus;
	always @(posedge i_clk_sys) last_bus <= i_data_pins;
	always @(posedge o_we_n) if (!o_ce_n) wr_cnt[o_data_pins]++;

	pfc_host #(.ERASE_PULSE_CYCLES(ERASE_CYC), .LAST_ADDR(16'h0003), .ERASE_MAX_PULSES(4)) dut (.*);
	pfc_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .ERASE_NS(ERASE_CYC * 40)) flash (
		.i_ce_n       (o_ce_n),
		.i_oe_n       (o_oe_n),
		.i_we_n       (o_we_n),
		.i_addr       (o_addr),
		.i_a9_high    (o_a9_high),
		.i_supply_high(o_programming_supply_high),
		.i_data       (i_data_pins),
		.i_prog_fail  (prog_fail),
		.o_data       (dev_d),
		.o_data_oe    (dev_oe)
	);

	task automatic stop_test();
		if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic cnt_is(input logic [7:0] code, input logic [7:0] exp);
		check("writes of command byte", exp, 8'(wr_cnt[code]));
	endtask : cnt_is

	task automatic run_cmd(input pfc_op_type op, input logic [15:0] a, input logic [7:0] d);
		int n;
		foreach (wr_cnt[i]) wr_cnt[i] = 0;
		i_cmd_valid <= 1'b1;
		i_cmd_op    <= op;
		i_cmd_addr  <= a;
		i_cmd_data  <= d;
		@(posedge i_clk_sys);
		i_cmd_valid <= 1'b0;
		n = 0;
		while (o_done !== 1'b1 && n < 20000) begin
			@(posedge i_clk_sys);
			n++;
		end
		if (n == 20000) begin
			mismatches++;
			stop_test();
		end
	endtask : run_cmd

	task automatic t_prog();
		run_cmd(OP_PROG, 16'h0010, 8'h5A);
		check("fail flag", 8'h00, {7'h00, o_fail});
		check("verify byte", 8'h5A, o_rdata);
		cnt_is(CMD_PROG, 8'h01);
		cnt_is(CMD_PROG_VFY, 8'h01);
		run_cmd(OP_PROG, 16'h0011, 8'h0F);
		check("verify byte", 8'h0F, o_rdata);
	endtask : t_prog

	task automatic t_read();
		run_cmd(OP_READ, 16'h0010, 8'h00);
		check("array byte", 8'h5A, o_rdata);
		cnt_is(CMD_READ, 8'h01);
		run_cmd(OP_READ, 16'hFFFF, 8'h00);
		check("array byte", 8'hFF, o_rdata);
	endtask : t_read

	task automatic t_ident();
		for (int b = 0; b < 2; b++) begin
			run_cmd(OP_SIG, {15'h0000, b[0]}, 8'h00);
			check("identity", b[0] ? PART_ID : MAKER_ID, o_rdata);
			run_cmd(OP_ID_A9, {15'h0000, b[0]}, 8'h00);
			check("line nine identity", b[0] ? PART_ID : MAKER_ID, o_rdata);
			cnt_is(CMD_SIG, 8'h00);
		end
	endtask : t_ident

	task automatic t_prog_fail();
		prog_fail <= 1'b1;
		run_cmd(OP_PROG, 16'h0020, 8'h33);
		check("fail flag", 8'h01, {7'h00, o_fail});
		cnt_is(CMD_PROG, 8'h19);
		prog_fail <= 1'b0;
		run_cmd(OP_READ, 16'h0020, 8'h00);
		check("fail flag", 8'h00, {7'h00, o_fail});
		check("array byte", 8'hFF, o_rdata);
	endtask : t_prog_fail

	task automatic t_erase();
		run_cmd(OP_ERASE, 16'h0000, 8'h00);
		check("fail flag", 8'h00, {7'h00, o_fail});
		check("verify byte", ERASED_BYTE, o_rdata);
		cnt_is(PRECOND_BYTE, 8'h04);
		cnt_is(CMD_ERASE, 8'h02);
		cnt_is(CMD_ERASE_VFY, 8'h04);
		run_cmd(OP_READ, 16'h0010, 8'h00);
		check("array byte", ERASED_BYTE, o_rdata);
	endtask : t_erase

	task automatic t_abort();
		run_cmd(OP_RESET, 16'h0000, 8'h00);
		cnt_is(CMD_RESET, 8'h02);
	endtask : t_abort

	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		t_prog();
		t_read();
		t_ident();
		t_prog_fail();
		t_erase();
		t_abort();
		stop_test();
	end
endmodule : tb_parallel_flash_command_interface

bind pfc_host pfc_host_sva u_sva (.*);
